// file: hw/fsw_sweep_ctrl.sv
// Purpose: trigger and step sequencing of the frequency sweeper
// Assumes: apb slave, one wait state; ext pin synchronous to ref_clk_i
// Notes:   the modulator arithmetic consumes ratio_step_o and friends
`timescale 1ns/1ps
`include "fsw_params.svh"
module fsw_sweep_ctrl
	import fsw_pkg::*;
#(
	parameter int DELAY_W = `FSW_DLY_W,
	parameter int STEP_W  = `FSW_STEP_W
) (
	input  wire logic                   ref_clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   psel_i,
	input  wire logic                   penable_i,
	input  wire logic                   pwrite_i,
	input  wire logic [`FSW_ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]            pwdata_i,
	output logic      [31:0]            prdata_o,
	output logic                        pready_o,
	output logic                        pslverr_o,
	input  wire logic                   ext_trigger_pin_i,
	output logic                        flag_output_pin_o,
	output logic                        sweep_active_o,
	output logic                        ratio_step_o,
	output logic                        ratio_up_o,
	output logic                        ratio_return_o
);
	generate
		if (DELAY_W != `FSW_DLY_W || STEP_W < 2 || STEP_W > 16) begin : g_bad
			$error("fsw_sweep_ctrl: unsupported parameter values");
		end
	endgenerate

	function automatic logic hit(input logic [`FSW_ADDR_W-1:0] a,
		input logic [7:0] idx);
		hit = (a == {idx, 2'h0});
	endfunction : hit

	// -------------------------------------------------------------
	// register state
	// -------------------------------------------------------------
	logic               gpio_en_r;
	logic [DELAY_W-1:0] dly_r;
	logic [3:0]         pin_sel_r;
	logic               pin_out_en_r;
	logic [1:0]         auto_r;
	logic               dly_en_r;
	logic               sweep_en_r;
	logic               src_r;
	logic               dir_init_r;
	logic               sstep_r;
	logic               oneway_r;
	logic [STEP_W-1:0]  nstep_r;
	logic [STEP_W-1:0]  ivl_r;
	logic               sw_trig_r;
	logic               pready_r;
	logic               pslverr_r;
	logic [31:0]        prdata_r;

	fsw_state_t         state_r;
	fsw_state_t         state_nxt;
	logic [STEP_W-1:0]  cnt_r;
	logic [STEP_W-1:0]  cnt_nxt;
	logic [STEP_W-1:0]  ivl_cnt_r;
	logic               dir_r;
	logic               dir_nxt;
	logic               busy_r;
	logic               busy_nxt;
	logic               ext_q_r;
	logic               flag_r;
	logic               step_r;
	logic               ret_r;

	logic               acc;
	logic               wr;
	logic               mapped;
	logic [31:0]        rd_data;
	logic               ext_ok;
	logic               ext_rise;
	logic               dly_fire;
	logic               trig;
	logic               auto_m;
	logic               tick;
	logic               adv;
	logic               start_go;
	logic               ramp_go;
	logic               dw_go;
	logic               step_go;
	logic               ret_go;
	logic               last;
	logic [STEP_W-1:0]  nstep_eff;

	// -------------------------------------------------------------
	// apb slave
	// -------------------------------------------------------------
	// one wait state keeps prdata and pready straight from flops
	assign acc = psel_i & penable_i;
	assign wr  = acc & pready_r & pwrite_i;

	always_comb begin
		mapped  = 1'b1;
		rd_data = 32'h0000_0000;
		if (hit(paddr_i, `FSW_IDX_GPIO)) begin
			rd_data[`FSW_GPIO_EN_BIT] = gpio_en_r;
		end else if (hit(paddr_i, `FSW_IDX_DLY)) begin
			rd_data[DELAY_W-1:0] = dly_r;
		end else if (hit(paddr_i, `FSW_IDX_PSEL)) begin
			rd_data[`FSW_PSEL_HI:`FSW_PSEL_LO] = pin_sel_r;
			rd_data[`FSW_PSEL_PINOUT] = pin_out_en_r;
		end else if (hit(paddr_i, `FSW_IDX_CFG)) begin
			rd_data[`FSW_CFG_AUTO_HI:`FSW_CFG_AUTO_LO] = auto_r;
			rd_data[`FSW_CFG_DLY_EN]   = dly_en_r;
			rd_data[`FSW_CFG_SWEEP_EN] = sweep_en_r;
			rd_data[`FSW_CFG_SRC]      = src_r;
			rd_data[`FSW_CFG_DIR_UP]   = dir_init_r;
			rd_data[`FSW_CFG_SSTEP]    = sstep_r;
			rd_data[`FSW_CFG_ONEWAY]   = oneway_r;
		end else if (hit(paddr_i, `FSW_IDX_NSTEP)) begin
			rd_data[STEP_W-1:0] = nstep_r;
		end else if (hit(paddr_i, `FSW_IDX_IVL)) begin
			rd_data[STEP_W-1:0] = ivl_r;
		end else if (hit(paddr_i, `FSW_IDX_STAT)) begin
			rd_data[STEP_W-1:0] = cnt_r;
			rd_data[`FSW_STAT_BUSY] = busy_r;
			rd_data[`FSW_STAT_DIR]  = dir_r;
			rd_data[`FSW_STAT_ST_HI:`FSW_STAT_ST_LO] = state_r;
		end else begin
			mapped = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= acc & ~pready_r;
			pslverr_r <= acc & ~pready_r & ~mapped;
			prdata_r  <= (acc & ~pready_r & ~pwrite_i) ? rd_data
				: 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			gpio_en_r    <= 1'b0;
			dly_r        <= `FSW_RST_DLY;
			pin_sel_r    <= 4'h0;
			pin_out_en_r <= 1'b0;
			auto_r       <= 2'h0;
			dly_en_r     <= 1'b0;
			sweep_en_r   <= 1'b0;
			src_r        <= 1'b0;
			dir_init_r   <= 1'b1;
			sstep_r      <= 1'b0;
			oneway_r     <= 1'b0;
			nstep_r      <= STEP_W'(`FSW_RST_NSTEP);
			ivl_r        <= STEP_W'(`FSW_RST_IVL);
		end else if (wr) begin
			if (hit(paddr_i, `FSW_IDX_GPIO)) begin
				gpio_en_r <= pwdata_i[`FSW_GPIO_EN_BIT];
			end
			if (hit(paddr_i, `FSW_IDX_DLY)) begin
				dly_r <= pwdata_i[DELAY_W-1:0];
			end
			if (hit(paddr_i, `FSW_IDX_PSEL)) begin
				pin_sel_r    <= pwdata_i[`FSW_PSEL_HI:`FSW_PSEL_LO];
				pin_out_en_r <= pwdata_i[`FSW_PSEL_PINOUT];
			end
			if (hit(paddr_i, `FSW_IDX_CFG)) begin
				auto_r     <= pwdata_i[`FSW_CFG_AUTO_HI:`FSW_CFG_AUTO_LO];
				dly_en_r   <= pwdata_i[`FSW_CFG_DLY_EN];
				sweep_en_r <= pwdata_i[`FSW_CFG_SWEEP_EN];
				src_r      <= pwdata_i[`FSW_CFG_SRC];
				dir_init_r <= pwdata_i[`FSW_CFG_DIR_UP];
				sstep_r    <= pwdata_i[`FSW_CFG_SSTEP];
				oneway_r   <= pwdata_i[`FSW_CFG_ONEWAY];
			end
			if (hit(paddr_i, `FSW_IDX_NSTEP)) begin
				nstep_r <= pwdata_i[STEP_W-1:0];
			end
			if (hit(paddr_i, `FSW_IDX_IVL)) begin
				ivl_r <= pwdata_i[STEP_W-1:0];
			end
		end
	end

	// -------------------------------------------------------------
	// trigger sources
	// -------------------------------------------------------------
	// write-one software trigger, self clearing
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sw_trig_r <= 1'b0;
		end else begin
			sw_trig_r <= wr & hit(paddr_i, `FSW_IDX_CFG)
				& pwdata_i[`FSW_CFG_SW_TRIG];
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_q_r <= 1'b0;
		end else begin
			ext_q_r <= ext_trigger_pin_i;
		end
	end

	assign ext_ok   = src_r & gpio_en_r & ~pin_out_en_r;
	assign ext_rise = ext_ok & ext_trigger_pin_i & ~ext_q_r;

	fsw_trig_delay #(
		.DELAY_W (DELAY_W)
	) u_delay (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.trig_i    (ext_rise & dly_en_r),
		.count_i   (dly_r),
		.fire_o    (dly_fire)
	);

	// source select; bypass when delay off
	assign trig = (~src_r & sw_trig_r) | (ext_rise & ~dly_en_r)
		| (dly_fire & ext_ok);

	// -------------------------------------------------------------
	// step sequencer
	// -------------------------------------------------------------
	// code 11 is automatic; user-defined auto is not supported
	assign auto_m    = (auto_r == `FSW_AUTO_CODE) & ~sstep_r;
	assign nstep_eff = (nstep_r == '0) ? STEP_W'(1) : nstep_r;
	// steps spaced by the interval timer
	assign tick      = (ivl_cnt_r <= STEP_W'(1));
	// single step waits per trigger; one step per trigger
	assign adv       = sstep_r ? trig : tick;

	// only while sweep enabled; auto starts itself
	assign start_go = sweep_en_r & (state_r == FSW_IDLE)
		& (trig | auto_m);
	assign ramp_go  = sweep_en_r & (state_r == FSW_RAMP) & adv;
	// triggered ramps wait for a trigger at the dwell
	assign dw_go    = sweep_en_r & (state_r == FSW_DWELL)
		& (auto_m ? tick : trig);
	// auto one-way restarts at once; mode bit
	assign step_go  = start_go | ramp_go | (dw_go & (~oneway_r | auto_m));
	// one-way jumps straight back to start
	assign ret_go   = dw_go & oneway_r;

	always_comb begin
		cnt_nxt   = (ramp_go ? cnt_r : STEP_W'(0)) + STEP_W'(1);
		last      = (cnt_nxt >= nstep_eff);
		dir_nxt   = dir_r;
		state_nxt = state_r;
		// first ramp takes the programmed direction
		if (start_go || (dw_go && oneway_r)) begin
			dir_nxt = dir_init_r;
		end else if (dw_go) begin
			dir_nxt = ~dir_r;
		end
		if (!sweep_en_r) begin
			state_nxt = FSW_IDLE;
		end else if (step_go) begin
			state_nxt = last ? FSW_DWELL : FSW_RAMP;
		end else if (ret_go) begin
			// the next trigger restarts from idle
			state_nxt = FSW_IDLE;
		end
		// busy from first step to last step
		busy_nxt = sweep_en_r & (step_go | (busy_r & state_r == FSW_RAMP));
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= FSW_IDLE;
			cnt_r   <= '0;
			dir_r   <= 1'b1;
			busy_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= step_go ? cnt_nxt : (ret_go ? '0 : cnt_r);
			dir_r   <= dir_nxt;
			busy_r  <= busy_nxt;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ivl_cnt_r <= '0;
		end else if (step_go || ret_go || state_r == FSW_IDLE) begin
			ivl_cnt_r <= ivl_r;
		end else if (ivl_cnt_r != '0) begin
			ivl_cnt_r <= ivl_cnt_r - STEP_W'(1);
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			step_r <= 1'b0;
			ret_r  <= 1'b0;
			flag_r <= 1'b0;
		end else begin
			step_r <= step_go;
			ret_r  <= ret_go;
			// busy on the flag pin when selected
			flag_r <= (pin_sel_r == `FSW_PSEL_BUSY) & busy_nxt;
		end
	end

	assign prdata_o          = prdata_r;
	assign pready_o          = pready_r;
	assign pslverr_o         = pslverr_r;
	assign flag_output_pin_o = flag_r;
	assign sweep_active_o    = busy_r;
	assign ratio_step_o      = step_r;
	assign ratio_up_o        = dir_r;
	assign ratio_return_o    = ret_r;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_busy_on_step: assert property (ratio_step_o |-> sweep_active_o)
		else $error("step issued while busy low");
	a_flag_follows: assert property ($past(pin_sel_r == `FSW_PSEL_BUSY)
		|-> flag_output_pin_o == sweep_active_o)
		else $error("flag pin does not show busy");
	a_sw_trig_start: assert property (sw_trig_r && !src_r && sweep_en_r
		&& state_r == FSW_IDLE |=> ratio_step_o)
		else $error("software trigger did not start sweep");
	a_src_blocks_pin: assert property (!src_r && !sw_trig_r && !auto_m
		&& state_r == FSW_IDLE |=> !ratio_step_o)
		else $error("pin trigger accepted with source 0");
	a_pin_gate: assert property (ext_rise |-> src_r && gpio_en_r
		&& !pin_out_en_r && ext_trigger_pin_i && !ext_q_r)
		else $error("pin trigger without its enables");
	a_bypass_now: assert property (ext_rise && !dly_en_r && sweep_en_r
		&& state_r == FSW_IDLE |=> ratio_step_o)
		else $error("undelayed trigger not applied at once");
	a_delay_one: assert property (ext_rise && dly_en_r
		&& dly_r == DELAY_W'(1) && src_r && gpio_en_r && !pin_out_en_r
		|=> trig)
		else $error("delay of one not applied at next edge");
	a_sweep_gate: assert property (!sweep_en_r |=> !ratio_step_o
		&& !ratio_return_o)
		else $error("sweep activity while disabled");
	a_auto_start: assert property (auto_m && sweep_en_r
		&& state_r == FSW_IDLE |=> ratio_step_o)
		else $error("automatic sweep did not start");
	a_single_step: assert property (sstep_r && !trig
		&& state_r == FSW_RAMP |=> !ratio_step_o)
		else $error("user step without trigger");
	a_return_oneway: assert property (ratio_return_o |-> $past(oneway_r)
		&& (!sweep_active_o || ratio_step_o))
		else $error("return outside one-way mode");
	a_dir_start: assert property (start_go
		|=> ratio_up_o == $past(dir_init_r))
		else $error("start direction wrong");
	a_two_way_flip: assert property (dw_go && !oneway_r
		|=> ratio_up_o != $past(dir_r))
		else $error("two-way ramp did not reverse");

	c_one_way_ret: cover property (ratio_return_o ##[1:50] ratio_step_o);
	c_two_way_rev: cover property (dw_go && !oneway_r);
	c_delayed_pin: cover property (dly_fire && state_r == FSW_IDLE);
	c_user_step:   cover property (sstep_r && ramp_go);
endmodule : fsw_sweep_ctrl

// file: hw/fsw_trig_delay.sv
// Purpose: postpones a trigger pulse by a programmed count of clock periods
// Assumes: count 0 acts as 1
// Notes:   a new trigger while counting restarts the count
`timescale 1ns/1ps
`include "fsw_params.svh"
module fsw_trig_delay
	import fsw_pkg::*;
#(
	parameter int DELAY_W = `FSW_DLY_W
) (
	input  wire logic               ref_clk_i,
	input  wire logic               rst_i,
	input  wire logic               trig_i,
	input  wire logic [DELAY_W-1:0] count_i,
	output logic                    fire_o
);
	logic [DELAY_W-1:0] cnt_r;
	logic               fire_r;

	generate
		if (DELAY_W < 2) begin : g_bad_w
			$error("fsw_trig_delay: DELAY_W too small");
		end
	endgenerate

	// -------------------------------------------------------------
	// countdown
	// -------------------------------------------------------------
	// count reference periods
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= '0;
		end else if (trig_i) begin
			cnt_r <= (count_i > DELAY_W'(1)) ? count_i - DELAY_W'(1) : '0;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - DELAY_W'(1);
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fire_r <= 1'b0;
		end else begin
			fire_r <= trig_i ? (count_i <= DELAY_W'(1))
				: (cnt_r == DELAY_W'(1));
		end
	end

	assign fire_o = fire_r;

	a_delay_one_edge: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		trig_i && count_i == DELAY_W'(1) |=> fire_o)
		else $error("delay of one did not fire at next edge");
endmodule : fsw_trig_delay

// file: pkg/fsw_params.svh
// Purpose: register map, field positions and reset values of the sweeper
// Assumes: apb word registers, byte address is four times the index
// Notes:   definitions only
`ifndef FSW_PARAMS_SVH
`define FSW_PARAMS_SVH

`define FSW_ADDR_W        10
`define FSW_IDX_GPIO      8'h01
`define FSW_IDX_DLY       8'h05
`define FSW_IDX_PSEL      8'h08
`define FSW_IDX_CFG       8'h0E
`define FSW_IDX_NSTEP     8'h20
`define FSW_IDX_IVL       8'h21
`define FSW_IDX_STAT      8'h22

`define FSW_GPIO_EN_BIT   4
`define FSW_PSEL_LO       0
`define FSW_PSEL_HI       3
`define FSW_PSEL_PINOUT   13
`define FSW_PSEL_BUSY     4'h8
`define FSW_CFG_AUTO_LO   2
`define FSW_CFG_AUTO_HI   3
`define FSW_CFG_DLY_EN    7
`define FSW_CFG_SWEEP_EN  11
`define FSW_CFG_SW_TRIG   12
`define FSW_CFG_SRC       13
`define FSW_CFG_DIR_UP    14
`define FSW_CFG_SSTEP     24
`define FSW_CFG_ONEWAY    25
`define FSW_AUTO_CODE     2'h3

`define FSW_DLY_W         21
`define FSW_STEP_W        16
`define FSW_RST_DLY       21'h000001
`define FSW_RST_NSTEP     16'h0010
`define FSW_RST_IVL       16'h0004
`define FSW_STAT_BUSY     16
`define FSW_STAT_DIR      17
`define FSW_STAT_ST_LO    18
`define FSW_STAT_ST_HI    19

`endif

// file: pkg/fsw_pkg.sv
// Purpose: shared types of the sweep trigger control
// Assumes: nothing
// Notes:   gray codes along idle, ramp, dwell
package fsw_pkg;
	typedef enum logic [1:0] {
		FSW_IDLE  = 2'h0,
		FSW_RAMP  = 2'h1,
		FSW_DWELL = 2'h3
	} fsw_state_t;
endpackage : fsw_pkg

// file: verification/fsw_trig_src.sv
// Purpose: external trigger source facing the sweeper's trigger pin
// Assumes: pin changes right after a rising edge of ref_clk_i
// Notes:   one-cycle high pulses; the bench chooses their spacing
`timescale 1ns/1ps
module fsw_trig_src (
	input  wire logic ref_clk_i,
	output logic      ext_trigger_pin_o
);
	initial ext_trigger_pin_o = 1'b0;

	// a rising edge, then low again
	task automatic pulse();
		ext_trigger_pin_o <= 1'b1;
	endtask : pulse

	// low between pulses, so every pulse gives a fresh rising edge
	always @(posedge ref_clk_i) begin
		if (ext_trigger_pin_o)
			ext_trigger_pin_o <= 1'b0;
	end
endmodule : fsw_trig_src

// file: verification/test_frequency_sweep_trigger_control.sv
// Purpose: self-checking bench of the sweep trigger control
// Assumes: outputs read at the edge, before that edge's updates land
// Notes:   each scenario starts from a fresh reset
`timescale 1ns/1ps
`include "fsw_params.svh"
module test_frequency_sweep_trigger_control
	import fsw_pkg::*;
;
	logic                   ref_clk_i = 1'b0;
	logic                   rst_i     = 1'b1;
	logic                   psel_i    = 1'b0;
	logic                   penable_i = 1'b0;
	logic                   pwrite_i  = 1'b0;
	logic [`FSW_ADDR_W-1:0] paddr_i   = '0;
	logic [31:0]            pwdata_i  = 32'h0;
	logic [31:0]            prdata_o;
	logic                   pready_o;
	logic                   pslverr_o;
	logic                   ext_pin;
	logic                   flag_pin;
	logic                   busy;
	logic                   step;
	logic                   up;
	logic                   ret;
	logic [31:0]            rd;
	logic                   err;
	int                     n_mismatch = 0;
	int                     n_compared = 0;

	always #25 ref_clk_i = ~ref_clk_i;

	fsw_sweep_ctrl i_dut (
		.ref_clk_i        (ref_clk_i),
		.rst_i            (rst_i),
		.psel_i           (psel_i),
		.penable_i        (penable_i),
		.pwrite_i         (pwrite_i),
		.paddr_i          (paddr_i),
		.pwdata_i         (pwdata_i),
		.prdata_o         (prdata_o),
		.pready_o         (pready_o),
		.pslverr_o        (pslverr_o),
		.ext_trigger_pin_i(ext_pin),
		.flag_output_pin_o(flag_pin),
		.sweep_active_o   (busy),
		.ratio_step_o     (step),
		.ratio_up_o       (up),
		.ratio_return_o   (ret)
	);

	fsw_trig_src i_src (
		.ref_clk_i        (ref_clk_i),
		.ext_trigger_pin_o(ext_pin)
	);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic end_sim();
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic check(input string nm, input logic [31:0] seen,
			input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic timed_out(input string nm);
		n_mismatch++;
		$display("BAD %s expected 1 seen 0", nm);
		end_sim();
	endtask : timed_out

	// waits stay bounded; the slave answer time is not assumed
	task automatic apb(input logic wr, input logic [7:0] idx,
			input logic [31:0] wd);
		int k;
		@(posedge ref_clk_i);
		psel_i   <= 1'b1;
		pwrite_i <= wr;
		paddr_i  <= {idx, 2'b00};
		pwdata_i <= wd;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge ref_clk_i);
			if (pready_o === 1'b1)
				break;
		end
		if (k == 16)
			timed_out("pready");
		rd = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	function automatic logic [31:0] cfg(input logic en, input logic src,
			input logic dly, input logic ss, input logic ow,
			input logic dir, input logic [1:0] au);
		cfg = 32'h0;
		cfg[`FSW_CFG_SWEEP_EN] = en;
		cfg[`FSW_CFG_SRC] = src;
		cfg[`FSW_CFG_DLY_EN] = dly;
		cfg[`FSW_CFG_SSTEP] = ss;
		cfg[`FSW_CFG_ONEWAY] = ow;
		cfg[`FSW_CFG_DIR_UP] = dir;
		cfg[`FSW_CFG_AUTO_HI:`FSW_CFG_AUTO_LO] = au;
	endfunction : cfg

	task automatic trig(input logic [31:0] c);
		apb(1'b1, `FSW_IDX_CFG, c | (32'h0000_0001 << `FSW_CFG_SW_TRIG));
	endtask : trig

	task automatic pin();
		@(posedge ref_clk_i);
		i_src.pulse();
	endtask : pin

	// counts edges until a step (sel 0) or return (sel 1) pulse
	task automatic ev(input logic sel, input int exp_k);
		int k;
		for (k = 1; k <= 40; k++) begin
			@(posedge ref_clk_i);
			if ((sel ? ret : step) === 1'b1)
				break;
		end
		if (k > 40)
			timed_out("ratio_event");
		if (exp_k > 0)
			check("event_delay", 32'(k), 32'(exp_k));
	endtask : ev

	task automatic no_step(input int n);
		repeat (n) begin
			@(posedge ref_clk_i);
			check("quiet", {30'h0, step, ret}, 32'h0);
		end
	endtask : no_step

	task automatic do_reset();
		@(posedge ref_clk_i);
		rst_i <= 1'b1;
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		apb(1'b1, `FSW_IDX_NSTEP, 32'h0000_0002);
		apb(1'b1, `FSW_IDX_IVL, 32'h0000_0004);
	endtask : do_reset

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic sc_regs();
		apb(1'b0, `FSW_IDX_CFG, 32'h0);
		check("cfg_reset", rd, 32'h0000_4000);
		apb(1'b0, `FSW_IDX_PSEL, 32'h0);
		check("psel_reset", rd, 32'h0000_0000);
		apb(1'b0, `FSW_IDX_DLY, 32'h0);
		check("dly_reset", rd, 32'(`FSW_RST_DLY));
		apb(1'b1, `FSW_IDX_DLY, 32'hFFFF_FFFF);
		apb(1'b0, `FSW_IDX_DLY, 32'h0);
		check("dly_width", rd, 32'h001F_FFFF);
		apb(1'b0, 8'h30, 32'h0);
		check("unmapped", {rd[30:0], err}, 32'h0000_0001);
	endtask : sc_regs

	task automatic sc_twoway();
		apb(1'b1, `FSW_IDX_PSEL, 32'h0000_0008);
		apb(1'b1, `FSW_IDX_GPIO, 32'h0000_0010);
		trig(cfg(0, 0, 0, 0, 0, 1, 2'h0));
		no_step(8);
		apb(1'b1, `FSW_IDX_CFG, cfg(1, 0, 0, 0, 0, 1, 2'h0));
		pin();
		no_step(8);
		trig(cfg(1, 0, 0, 0, 0, 1, 2'h0));
		ev(0, 2);
		check("first_step", {busy, flag_pin, up}, 32'h7);
		ev(0, 4);
		check("last_busy", {busy, flag_pin}, 32'h3);
		@(posedge ref_clk_i);
		check("busy_end", {busy, flag_pin}, 32'h0);
		no_step(8);
		trig(cfg(1, 0, 0, 0, 0, 1, 2'h0));
		ev(0, 2);
		check("reverse_dir", {31'h0, up}, 32'h0);
	endtask : sc_twoway

	task automatic sc_auto();
		trig(cfg(1, 0, 0, 0, 0, 1, 2'h3));
		ev(0, 2);
		ev(0, 4);
		ev(0, 4);
		check("auto_reverse", {31'h0, up}, 32'h0);
		ev(0, 4);
	endtask : sc_auto

	task automatic sc_oneway();
		trig(cfg(1, 0, 0, 0, 1, 0, 2'h0));
		ev(0, 2);
		check("down_start", {31'h0, up}, 32'h0);
		ev(0, 4);
		trig(cfg(1, 0, 0, 0, 1, 0, 2'h0));
		ev(1, 2);
		// restart trigger spaced for oscillator settling
		// settle gap
		repeat (10) @(posedge ref_clk_i);
		trig(cfg(1, 0, 0, 0, 1, 0, 2'h0));
		ev(0, 2);
	endtask : sc_oneway

	task automatic sc_user();
		apb(1'b1, `FSW_IDX_CFG, cfg(1, 1, 0, 1, 1, 1, 2'h0));
		pin();
		no_step(8);
		apb(1'b1, `FSW_IDX_GPIO, 32'h0000_0010);
		pin();
		ev(0, 2);
		no_step(8);
		apb(1'b1, `FSW_IDX_DLY, 32'h0000_0003);
		apb(1'b1, `FSW_IDX_CFG, cfg(1, 1, 1, 1, 1, 1, 2'h0));
		pin();
		ev(0, 5);
		pin();
		ev(1, 5);
		apb(1'b1, `FSW_IDX_DLY, 32'h0000_0001);
		pin();
		ev(0, 3);
		apb(1'b1, `FSW_IDX_CFG, cfg(1, 1, 1, 1, 0, 1, 2'h0));
		pin();
		ev(0, 3);
	endtask : sc_user

	initial begin
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		sc_regs();
		do_reset();
		sc_twoway();
		do_reset();
		sc_auto();
		do_reset();
		sc_oneway();
		do_reset();
		sc_user();
		end_sim();
	end
endmodule : test_frequency_sweep_trigger_control
